// ### next_address_defs.svh
// Register offsets, field positions, reset values and widths of the sequencer.
`ifndef NEXT_ADDRESS_DEFS_SVH
`define NEXT_ADDRESS_DEFS_SVH

`define OFS_CONTROL      12'h000
`define OFS_STATUS       12'h004
`define OFS_ADDRESS      12'h008

`define CTRL_RUN_BIT     0
`define CTRL_RESET       32'h0000_0001
`define ADDR_RESET       9'h000
`define LATCH_RESET      4'h0

`define STAT_ADDR_LSB    0
`define STAT_LATCH_LSB   9
`define STAT_FUNC_LSB    13

`define ROW_MSB          8
`define ROW_LSB          4
`define COL_MSB          3

`endif

// ### next_address_pkg.sv
// Types shared by the next-address selection logic.
`default_nettype none
package next_address_pkg;
  typedef enum {
    jump_current_column,
    jump_row_zero,
    jump_current_row,
    jump_column_enable,
    test_flag_latch,
    test_carry,
    test_zero,
    test_priority_latch,
    test_left_latch_bits,
    test_right_latch_bits,
    test_external_bus
  } next_func_t;
endpackage
`default_nettype wire

// ### next_address_decode.sv
// Combinational next-address former from the address-control field.
`default_nettype none
module next_address_decode (
  input  wire logic [6:0] address_control_field,
  input  wire logic [8:0] current_address,
  input  wire logic [3:0] priority_latch,
  input  wire logic [7:4] external_test_bus_n,
  input  wire logic       carry_flag,
  input  wire logic       zero_flag,
  input  wire logic       flag_latch,
  output logic      [8:0] next_address,
  output logic      [3:0] func_code
);

  function automatic next_address_pkg::next_func_t decode_func(
    input logic [6:0] ac
  );
    next_address_pkg::next_func_t f;
    f = next_address_pkg::jump_current_column;
    if (ac[6:5] == 2'b00) begin
      f = next_address_pkg::jump_current_column;
    end else if (ac[6:4] == 3'b010) begin
      f = next_address_pkg::jump_row_zero;
    end else if (ac[6:4] == 3'b011) begin
      f = next_address_pkg::jump_current_row;
    end else if (ac[6:4] == 3'b100) begin
      f = next_address_pkg::test_flag_latch;
    end else if (ac[6:3] == 4'b1010) begin
      f = next_address_pkg::test_carry;
    end else if (ac[6:3] == 4'b1011) begin
      f = next_address_pkg::test_zero;
    end else if (ac[6:3] == 4'b1100) begin
      f = next_address_pkg::test_priority_latch;
    end else if (ac[6:3] == 4'b1101) begin
      f = next_address_pkg::test_left_latch_bits;
    end else if (ac[6:3] == 4'b1110) begin
      f = next_address_pkg::jump_column_enable;
    end else if (ac[2] == 1'b1) begin
      f = next_address_pkg::test_right_latch_bits;
    end else begin
      f = next_address_pkg::test_external_bus;
    end
    return f;
  endfunction

  next_address_pkg::next_func_t func;
  logic [6:0] ac;
  logic [8:0] m;

  assign ac = address_control_field;
  assign m  = current_address;

  always_comb begin
    func = decode_func(ac);
    func_code = 4'(func);
    case (func)
      next_address_pkg::jump_current_column:
        next_address = {ac[4:0], m[3:0]};
      next_address_pkg::jump_row_zero:
        next_address = {5'h00, ac[3:0]};
      next_address_pkg::jump_current_row:
        next_address = {m[8:4], ac[3:0]};
      next_address_pkg::jump_column_enable:
        next_address = {m[8:7], ac[2:0], m[3:0]};
      next_address_pkg::test_flag_latch:
        next_address = {m[8], ac[3:0], m[3], 2'b01, flag_latch};
      next_address_pkg::test_carry:
        next_address = {m[8:7], ac[2:0], m[3], 2'b01, carry_flag};
      next_address_pkg::test_zero:
        next_address = {m[8:7], ac[2:0], m[3], 2'b01, zero_flag};
      next_address_pkg::test_priority_latch:
        next_address = {m[8:7], ac[2:0], priority_latch};
      next_address_pkg::test_left_latch_bits:
        next_address = {m[8:7], ac[2:0], 2'b01, priority_latch[3:2]};
      next_address_pkg::test_right_latch_bits:
        next_address = {m[8:7], 1'b1, ac[1:0], 2'b11, priority_latch[1:0]};
      next_address_pkg::test_external_bus:
        next_address = {m[8:6], ac[1:0], external_test_bus_n[7:4]};
      default:
        next_address = m;
    endcase
  end

endmodule
`default_nettype wire

// ### next_address_select.sv
// Microprogram address register, priority latch and APB register slave.
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`include "next_address_defs.svh"
`default_nettype none
module next_address_select (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [6:0]  address_control_field,
  input  wire logic [7:4]  external_test_bus_n,
  input  wire logic [3:0]  system_bus_low,
  input  wire logic        carry_flag,
  input  wire logic        zero_flag,
  input  wire logic        flag_latch,
  output logic      [8:0]  microprogram_address,
  output logic      [3:0]  priority_latch
);

  logic [8:0]  next_address;
  logic [3:0]  func_code;
  logic        run;
  logic        next_run;
  logic [8:0]  next_microprogram_address;
  logic [3:0]  next_priority_latch;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        setup;
  logic        wr_take;
  logic        advance;
  logic        ext_test;

  // Decode is combinational so the address is ready before the edge.
  next_address_decode u_decode (
    .address_control_field (address_control_field),
    .current_address       (microprogram_address),
    .priority_latch        (priority_latch),
    .external_test_bus_n   (external_test_bus_n),
    .carry_flag            (carry_flag),
    .zero_flag             (zero_flag),
    .flag_latch            (flag_latch),
    .next_address          (next_address),
    .func_code             (func_code)
  );

  function automatic logic addr_mapped(input logic [11:0] a);
    return (a == `OFS_CONTROL) || (a == `OFS_STATUS) ||
           (a == `OFS_ADDRESS);
  endfunction

  assign setup    = psel && !penable;
  assign wr_take  = psel && penable && pready && pwrite &&
                    addr_mapped(paddr);
  assign advance  = run;
  assign ext_test = func_code ==
                    4'(next_address_pkg::test_external_bus);

  // A software write of the address register wins over sequencing.
  always_comb begin
    next_microprogram_address = microprogram_address;
    next_priority_latch       = priority_latch;
    next_run                  = run;
    if (wr_take && paddr == `OFS_CONTROL) begin
      next_run = pwdata[`CTRL_RUN_BIT];
    end
    if (wr_take && paddr == `OFS_ADDRESS) begin
      next_microprogram_address = pwdata[8:0];
    end else if (advance) begin
      next_microprogram_address = next_address;
    end
    if (advance && ext_test) begin
      next_priority_latch = system_bus_low;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      microprogram_address <= `ADDR_RESET;
      priority_latch       <= `LATCH_RESET;
      run                  <= 1'(`CTRL_RESET);
    end else if (clk_en) begin
      microprogram_address <= next_microprogram_address;
      priority_latch       <= next_priority_latch;
      run                  <= next_run;
    end
  end

  // Ready is raised for one cycle after each setup cycle that sees clk_en high; a low clk_en holds it as it is.
  always_comb begin
    next_pready  = setup;
    next_pslverr = setup && !addr_mapped(paddr);
    next_prdata  = 32'h0000_0000;
    if (setup && !pwrite) begin
      case (paddr)
        `OFS_CONTROL: next_prdata = {31'h0000_0000, run};
        `OFS_STATUS: begin
          next_prdata[`STAT_ADDR_LSB +: 9]  = microprogram_address;
          next_prdata[`STAT_LATCH_LSB +: 4] = priority_latch;
          next_prdata[`STAT_FUNC_LSB +: 4]  = func_code;
        end
        `OFS_ADDRESS: next_prdata = {23'h00_0000, microprogram_address};
        default:      next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  logic [6:0] ac;
  logic [8:0] ma;
  assign ac = address_control_field;
  assign ma = microprogram_address;

  a_jcc_row: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && run && !wr_take && ac[6:5] == 2'b00 |=>
      ma == {$past(ac[4:0]), $past(ma[3:0])})
    else $error("current column jump formed wrong address");

  a_jzr_zero: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && run && !wr_take && ac[6:4] == 3'b010 |=>
      ma[8:4] == 5'h00 && ma[3:0] == $past(ac[3:0]))
    else $error("zero row jump formed wrong address");

  a_jcr_row: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && run && !wr_take && ac[6:4] == 3'b011 |=>
      ma == {$past(ma[8:4]), $past(ac[3:0])})
    else $error("current row jump formed wrong address");

  a_jce_col: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && run && !wr_take && ac[6:3] == 4'b1110 |=>
      ma == {$past(ma[8:7]), $past(ac[2:0]), $past(ma[3:0])})
    else $error("column enable jump formed wrong address");

  a_flag_test: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && run && !wr_take && ac[6:4] == 3'b100 |=>
      ma == {$past(ma[8]), $past(ac[3:0]), $past(ma[3]), 2'b01,
             $past(flag_latch)})
    else $error("flag latch test formed wrong address");

  a_carry_zero: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && run && !wr_take && ac[6:4] == 3'b101 |=>
      ma[2:1] == 2'b01 && ma[3] == $past(ma[3]) &&
      ma[0] == ($past(ac[3]) ? $past(zero_flag) : $past(carry_flag)))
    else $error("carry or zero test formed wrong column");

  a_prio_col: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && run && !wr_take && ac[6:3] == 4'b1100 |=>
      ma[3:0] == $past(priority_latch) && ma[6:4] == $past(ac[2:0]))
    else $error("priority latch test formed wrong address");

  a_left_bits: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && run && !wr_take && ac[6:3] == 4'b1101 |=>
      ma[3:0] == {2'b01, $past(priority_latch[3:2])})
    else $error("left latch bits test formed wrong column");

  a_right_bits: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && run && !wr_take && ac[6:2] == 5'b11111 |=>
      ma == {$past(ma[8:7]), 1'b1, $past(ac[1:0]), 2'b11,
             $past(priority_latch[1:0])})
    else $error("right latch bits test formed wrong address");

  a_ext_bus: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && run && !wr_take && ac[6:2] == 5'b11110 |=>
      ma == {$past(ma[8:6]), $past(ac[1:0]), $past(external_test_bus_n)} &&
      priority_latch == $past(system_bus_low))
    else $error("external bus test formed wrong address or latch");

  a_hold_stop: assert property (@(posedge pclk) disable iff (!presetn)
    (!clk_en || !run) && !wr_take |=> $stable(ma) && $stable(priority_latch))
    else $error("address changed while sequencing was held");

  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && psel && !penable |=> pready ##1 (!pready || !$past(clk_en)))
    else $error("ready did not follow the setup cycle for one cycle");

  // Register bus checks; a low enable freezes every answer in place.
  a_apb_freeze: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_en |=> $stable(pready) && $stable(pslverr) && $stable(prdata))
    else $error("bus outputs changed while the enable was low");

  a_freeze_all: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_en |=> $stable(run) && $stable(ma) && $stable(priority_latch))
    else $error("sequencer state changed while the enable was low");

  a_ready_idle: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !setup |=> !pready)
    else $error("ready rose without a setup cycle");

  a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error response stood without ready");

  a_data_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data stood outside an access cycle");

  a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && setup && !addr_mapped(paddr) |=>
      pready && pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access did not answer with an error");

  a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && setup && addr_mapped(paddr) |=> pready && !pslverr)
    else $error("mapped access answered with an error");

  a_write_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && setup && pwrite |=> prdata == 32'h0000_0000)
    else $error("write access drove read data");

  a_read_ctrl: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && setup && !pwrite && paddr == `OFS_CONTROL |=>
      prdata == {31'h0000_0000, $past(run)})
    else $error("control read returned wrong data");

  a_read_addr: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && setup && !pwrite && paddr == `OFS_ADDRESS |=>
      prdata == {23'h00_0000, $past(ma)})
    else $error("address read returned wrong data");

  a_status_fields: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && setup && !pwrite && paddr == `OFS_STATUS |=>
      prdata[12:0] == {$past(priority_latch), $past(ma)})
    else $error("status read returned wrong address or latch");

  a_status_func: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && setup && !pwrite && paddr == `OFS_STATUS |=>
      prdata[31:13] == {15'h0000, $past(func_code)})
    else $error("status read returned wrong function field");

  a_status_ext: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && setup && !pwrite && paddr == `OFS_STATUS &&
      ac[6:2] == 5'b11110 |=> prdata[16:13] == 4'ha)
    else $error("status read did not report the external bus test");

  a_addr_write: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wr_take && paddr == `OFS_ADDRESS |=>
      ma == $past(pwdata[8:0]))
    else $error("address write did not load the address register");

  a_run_write: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wr_take && paddr == `OFS_CONTROL |=>
      run == $past(pwdata[`CTRL_RUN_BIT]))
    else $error("control write did not load the run bit");

  a_run_hold: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !(wr_take && paddr == `OFS_CONTROL) |=>
      $stable(run))
    else $error("run bit changed without a control write");

  a_bad_write_keep: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && psel && penable && pready && pwrite &&
      !addr_mapped(paddr) |=> $stable(run))
    else $error("unmapped write changed the run bit");

  a_latch_keep: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !ext_test |=> $stable(priority_latch))
    else $error("priority latch changed outside the external bus test");

  c_ext_bus: cover property (@(posedge pclk) disable iff (!presetn)
    clk_en && run && ac[6:2] == 5'b11110);
  c_prio_after: cover property (@(posedge pclk) disable iff (!presetn)
    clk_en && run && ac[6:2] == 5'b11110 ##1 clk_en && ac[6:3] == 4'b1100);
  c_addr_write: cover property (@(posedge pclk) disable iff (!presetn)
    wr_take && paddr == `OFS_ADDRESS);
  c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn)
    pready && pslverr);
  c_right_bits: cover property (@(posedge pclk) disable iff (!presetn)
    clk_en && run && ac[6:2] == 5'b11111);

endmodule
`default_nettype wire

// ### control_store_model.sv
// Control store model that feeds the address-control field.
`default_nettype none
module control_store_model (
  input  wire logic [8:0] microprogram_address,
  output logic      [6:0] address_control_field
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] mem [512];
  initial begin
    foreach (mem[i]) mem[i] = 7'h00;
  end
  // The field comes straight from the store, with no pipeline stage.
  assign address_control_field = mem[microprogram_address];
endmodule
`default_nettype wire

// ### microprogram_next_address_select_tb.sv
// Self-checking bench for the next-address selection logic.
`default_nettype none
module microprogram_next_address_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, clk_en = 1;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, cf = 0, zf = 0, fl = 0, seq_on = 0;
  logic [6:0]  acf;
  logic [7:4]  xbus_n = 4'hf;
  logic [3:0]  sbl = 4'h0, pl, ep;
  logic [8:0]  ma, em;
  logic [32:0] apb_q[$];
  logic [12:0] seq_q[$];
  int          bad_count = 0;
  int          checked = 0;
  logic [6:0]  base [11] = '{7'h00, 7'h20, 7'h30, 7'h70, 7'h40, 7'h50,
                             7'h58, 7'h78, 7'h60, 7'h68, 7'h7c};
  logic [6:0]  mask [11] = '{7'h1f, 7'h0f, 7'h0f, 7'h07, 7'h0f, 7'h07,
                             7'h07, 7'h03, 7'h07, 7'h07, 7'h03};

  always #4 pclk = ~pclk;

  next_address_select i_next_address_select (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .address_control_field(acf), .external_test_bus_n(xbus_n),
    .system_bus_low(sbl), .carry_flag(cf), .zero_flag(zf),
    .flag_latch(fl), .microprogram_address(ma), .priority_latch(pl)
  );

  control_store_model i_control_store_model (
    .microprogram_address(ma), .address_control_field(acf)
  );

  task automatic check(string what, logic [32:0] e, logic [32:0] s);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask

  task test_done;
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
                     logic [32:0] e);
    if (!w) apb_q.push_back(e);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask

  // Expected {latch, address} after one enabled edge.
  function automatic logic [12:0] nxt(logic [6:0] a, logic [8:0] m,
      logic [3:0] p, logic [3:0] x, logic [3:0] s, logic c, z, f);
    casez (a)
      7'b00?_????: return {p, a[4:0], m[3:0]};
      7'b010_????: return {p, 5'h00, a[3:0]};
      7'b011_????: return {p, m[8:4], a[3:0]};
      7'b100_????: return {p, m[8], a[3:0], m[3], 2'h1, f};
      7'b101_0???: return {p, m[8:7], a[2:0], m[3], 2'h1, c};
      7'b101_1???: return {p, m[8:7], a[2:0], m[3], 2'h1, z};
      7'b110_0???: return {p, m[8:7], a[2:0], p};
      7'b110_1???: return {p, m[8:7], a[2:0], 2'h1, p[3:2]};
      7'b111_0???: return {p, m[8:7], a[2:0], m[3:0]};
      7'b111_10??: return {s, m[8:6], a[1:0], x};
      default: return {p, m[8:7], 1'b1, a[1:0], 2'h3, p[1:0]};
    endcase
  endfunction

  task automatic step(logic [6:0] a);
    logic       e;
    logic [3:0] x, s;
    logic       c, z, f;
    e = ($urandom % 8) != 0;
    x = 4'($urandom);
    s = 4'($urandom);
    {c, z, f} = 3'($urandom);
    @(posedge pclk);
    i_control_store_model.mem[em] <= a;
    clk_en <= e;
    xbus_n <= x;
    sbl <= s;
    cf <= c;
    zf <= z;
    fl <= f;
    seq_on <= 1;
    if (e) {ep, em} = nxt(a, em, ep, x, s, c, z, f);
    seq_q.push_back({ep, em});
  endtask

  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      check("apb read", apb_q.pop_front(), {pslverr, prdata});

  always @(posedge pclk) begin
    if (seq_on) begin
      @(negedge pclk);
      check("latch, address", {20'h0_0000, seq_q.pop_front()},
            {20'h0_0000, pl, ma});
    end
  end

  initial begin
    #40000;
    bad_count++;
    test_done();
  end

  initial begin
    void'($urandom(30));
    repeat (2) @(posedge pclk);
    presetn <= 1;
    // A current-row jump to itself keeps the address parked at 0x155.
    i_control_store_model.mem[9'h155] <= 7'h35;
    apb(0, 12'h000, 32'h0000_0000, {1'b0, 32'h0000_0001});
    apb(1, 12'h000, 32'h0000_0000, 33'h0_0000_0000);
    apb(1, 12'h008, 32'h0000_0155, 33'h0_0000_0000);
    apb(0, 12'h008, 32'h0000_0000, {1'b0, 32'h0000_0155});
    apb(0, 12'h004, 32'h0000_0000, {1'b0, 32'h0000_4155});
    apb(0, 12'h00c, 32'h0000_0000, {1'b1, 32'h0000_0000});
    em = 9'h155;
    ep = 4'h0;
    apb(1, 12'h000, 32'h0000_0001, 33'h0_0000_0000);
    for (int r = 0; r < 16; r++)
      for (int k = 0; k < 11; k++)
        step(base[k] | (7'($urandom) & mask[k]));
    @(posedge pclk);
    seq_on <= 0;
    clk_en <= 1;
    repeat (3) @(posedge pclk);
    test_done();
  end
endmodule
`default_nettype wire
